/* File: rtl/gpio_pkg.sv */
// Constants, offsets and reset values for the general-purpose I/O port block
//------------------------------------------------------------
//------------------------------------------------------------
package gpio_pkg;
	localparam logic [11:0] OFF_DIR = 12'h400;
	localparam logic [11:0] OFF_SENSE = 12'h404;
	localparam logic [11:0] OFF_BOTH = 12'h408;
	localparam logic [11:0] OFF_POL = 12'h40C;
	localparam logic [11:0] OFF_MASK = 12'h410;
	localparam logic [11:0] OFF_RAW = 12'h414;
	localparam logic [11:0] OFF_MIS = 12'h418;
	localparam logic [11:0] OFF_CLR = 12'h41C;
	localparam logic [11:0] OFF_ALT = 12'h420;
	localparam logic [11:0] OFF_DR2 = 12'h500;
	localparam logic [11:0] OFF_DR4 = 12'h504;
	localparam logic [11:0] OFF_DR8 = 12'h508;
	localparam logic [11:0] OFF_ODR = 12'h50C;
	localparam logic [11:0] OFF_PUR = 12'h510;
	localparam logic [11:0] OFF_PDR = 12'h514;
	localparam logic [11:0] OFF_SLR = 12'h518;
	localparam logic [11:0] OFF_DEN = 12'h51C;
	localparam logic [11:0] OFF_LOCK = 12'h520;
	localparam logic [11:0] OFF_COMMIT = 12'h524;
	localparam logic [11:0] OFF_ID_BASE = 12'hFD0;
	localparam int DATA_MASK_LSB = 2;
	localparam logic [7:0] RST_DR2 = 8'hFF;
	localparam logic [31:0] LOCK_KEY = 32'h1ACCE551;
	localparam logic [31:0] LOCKED_READ = 32'h00000001;
endpackage

/* File: rtl/gpio_port_pin_control.sv */
// One general-purpose I/O port: data, direction, interrupts, alternate function, pad control
module gpio_port_pin_control #(
	parameter logic [7:0] DEBUG_PINS = 8'h00,
	// Identification values are arbitrary
	parameter logic [7:0] ID_VALUE0 = 8'h11,
	parameter logic [7:0] ID_VALUE1 = 8'h22
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [11:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// Peripheral alternate functions
	input wire logic [7:0] alt_out,
	input wire logic [7:0] alt_oe,
	output logic [7:0] alt_in,
	// Pad configuration
	output logic [7:0] pad_dr2,
	output logic [7:0] pad_dr4,
	output logic [7:0] pad_dr8,
	output logic [7:0] pad_odr,
	output logic [7:0] pad_pur,
	output logic [7:0] pad_pdr,
	output logic [7:0] pad_slr,
	output logic [7:0] pad_den,
	// Combined interrupt
	output logic irq
);
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] sense;
		logic [7:0] both;
		logic [7:0] pol;
		logic [7:0] mask;
		logic [7:0] raw;
		logic [7:0] alt;
		logic [7:0] dr2;
		logic [7:0] dr4;
		logic [7:0] dr8;
		logic [7:0] odr;
		logic [7:0] pur;
		logic [7:0] pdr;
		logic [7:0] slr;
		logic [7:0] den;
		logic unlocked;
		logic [7:0] commit;
		logic ack;
		logic [31:0] rdata;
		logic [7:0] pout;
		logic [7:0] poe;
		logic [7:0] ain;
		logic irq;
	} state_t;

	state_t s;
	state_t next_s;

	//------------------------------------------------------------
	// Register read decode
	//------------------------------------------------------------
	// Data register window: every word of the low kilobyte
	function automatic logic is_data_window(input logic [11:0] a);
		return a[11:10] == 2'h0;
	endfunction

	function automatic logic [31:0] read_mux(input state_t st, input logic [11:0] a, input logic [7:0] din);
		logic [31:0] r;
		r = 32'h00000000;
		if (is_data_window(a)) begin
			r = {24'h000000, din & a[9:2]};
		end else begin
			case (a)
				gpio_pkg::OFF_DIR: r = {24'h000000, st.dir};
				gpio_pkg::OFF_SENSE: r = {24'h000000, st.sense};
				gpio_pkg::OFF_BOTH: r = {24'h000000, st.both};
				gpio_pkg::OFF_POL: r = {24'h000000, st.pol};
				gpio_pkg::OFF_MASK: r = {24'h000000, st.mask};
				gpio_pkg::OFF_RAW: r = {24'h000000, st.raw};
				gpio_pkg::OFF_MIS: r = {24'h000000, st.raw & st.mask};
				gpio_pkg::OFF_ALT: r = {24'h000000, st.alt};
				gpio_pkg::OFF_DR2: r = {24'h000000, st.dr2};
				gpio_pkg::OFF_DR4: r = {24'h000000, st.dr4};
				gpio_pkg::OFF_DR8: r = {24'h000000, st.dr8};
				gpio_pkg::OFF_ODR: r = {24'h000000, st.odr};
				gpio_pkg::OFF_PUR: r = {24'h000000, st.pur};
				gpio_pkg::OFF_PDR: r = {24'h000000, st.pdr};
				gpio_pkg::OFF_SLR: r = {24'h000000, st.slr};
				gpio_pkg::OFF_DEN: r = {24'h000000, st.den};
				gpio_pkg::OFF_LOCK: r = st.unlocked ? 32'h00000000 : gpio_pkg::LOCKED_READ;
				gpio_pkg::OFF_COMMIT: r = {24'h000000, st.commit};
				gpio_pkg::OFF_ID_BASE: r = {24'h000000, ID_VALUE0};
				gpio_pkg::OFF_ID_BASE + 12'h004: r = {24'h000000, ID_VALUE1};
				default: r = 32'h00000000;
			endcase
		end
		return r;
	endfunction

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	logic [7:0] level_in;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] edge_hit;
	logic [7:0] level_hit;
	logic [7:0] event_hit;
	logic [7:0] din;
	logic [7:0] wmask;
	logic [7:0] wd;
	logic req;
	logic wr_go;

	always_comb begin
		next_s = s;
		level_in = s.sync2;
		rise = level_in & ~s.prev;
		fall = ~level_in & s.prev;
		edge_hit = s.both & (rise | fall) | ~s.both & (s.pol & rise | ~s.pol & fall);
		level_hit = s.pol & level_in | ~s.pol & ~level_in;
		event_hit = s.sense & level_hit | ~s.sense & edge_hit;
		din = s.dir & s.data | ~s.dir & level_in;
		wmask = address[9:2];
		wd = writedata[7:0];
		req = (read | write) & ~s.ack;
		wr_go = write & s.ack;
		next_s.sync1 = pin_in;
		next_s.sync2 = s.sync1;
		next_s.prev = level_in;
		next_s.data = s.dir & s.data | ~s.dir & level_in;
		next_s.ack = req;
		next_s.rdata = s.rdata;
		if (req && read) begin
			next_s.rdata = read_mux(s, address, din);
		end
		// Set wins over clear
		next_s.raw = s.raw;
		if (wr_go && address == gpio_pkg::OFF_CLR) begin
			next_s.raw = s.raw & ~wd;
		end
		next_s.raw = next_s.raw | event_hit;
		// Writes land at the edge where waitrequest is seen low
		if (wr_go) begin
			if (is_data_window(address)) begin
				next_s.data = (s.dir & ((s.data & ~wmask) | (wd & wmask))) | (~s.dir & level_in);
			end
			case (address)
				gpio_pkg::OFF_DIR: next_s.dir = wd;
				gpio_pkg::OFF_SENSE: next_s.sense = wd;
				gpio_pkg::OFF_BOTH: next_s.both = wd;
				gpio_pkg::OFF_POL: next_s.pol = wd;
				gpio_pkg::OFF_MASK: next_s.mask = wd;
				gpio_pkg::OFF_ALT: next_s.alt = (s.alt & ~s.commit) | (wd & s.commit);
				gpio_pkg::OFF_DR2: begin
					next_s.dr2 = wd;
					next_s.dr4 = s.dr4 & ~wd;
					next_s.dr8 = s.dr8 & ~wd;
				end
				gpio_pkg::OFF_DR4: begin
					next_s.dr4 = wd;
					next_s.dr2 = s.dr2 & ~wd;
					next_s.dr8 = s.dr8 & ~wd;
				end
				gpio_pkg::OFF_DR8: begin
					next_s.dr8 = wd;
					next_s.dr2 = s.dr2 & ~wd;
					next_s.dr4 = s.dr4 & ~wd;
				end
				gpio_pkg::OFF_ODR: next_s.odr = wd;
				gpio_pkg::OFF_PUR: next_s.pur = wd;
				gpio_pkg::OFF_PDR: next_s.pdr = wd;
				gpio_pkg::OFF_SLR: next_s.slr = wd;
				gpio_pkg::OFF_DEN: next_s.den = wd;
				gpio_pkg::OFF_LOCK: next_s.unlocked = (writedata == gpio_pkg::LOCK_KEY);
				gpio_pkg::OFF_COMMIT: begin
					if (s.unlocked) begin
						next_s.commit = (wd & DEBUG_PINS) | ~DEBUG_PINS;
					end
				end
				default: next_s.unlocked = s.unlocked;
			endcase
		end
		// Pin drive: peripheral or software control
		next_s.pout = s.alt & alt_out | ~s.alt & next_s.data;
		next_s.poe = s.alt & alt_oe | ~s.alt & s.dir;
		next_s.ain = level_in & s.den;
		next_s.irq = |(next_s.raw & s.mask);
		if (!rst_n) begin
			next_s = '0;
			next_s.alt = DEBUG_PINS;
			next_s.den = DEBUG_PINS;
			next_s.pur = DEBUG_PINS;
			next_s.dr2 = gpio_pkg::RST_DR2;
			next_s.commit = ~DEBUG_PINS;
		end
	end

	// Level raw bits re-set while level holds; software clears after source releases.
	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign readdata = s.rdata;
	assign waitrequest = ~s.ack;
	assign pin_out = s.pout;
	assign pin_oe = s.poe;
	assign alt_in = s.ain;
	assign pad_dr2 = s.dr2;
	assign pad_dr4 = s.dr4;
	assign pad_dr8 = s.dr8;
	assign pad_odr = s.odr;
	assign pad_pur = s.pur;
	assign pad_pdr = s.pdr;
	assign pad_slr = s.slr;
	assign pad_den = s.den;
	assign irq = s.irq;

	//------------------------------------------------------------
	// Assertions: bus handshake
	//------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ack_single: assert property (s.ack |=> !s.ack)
		else $error("waitrequest low twice");

	a_read_hold: assert property (!(req && read) |=> $stable(readdata))
		else $error("read data moved");

	//------------------------------------------------------------
	// Assertions: interrupt detection
	//------------------------------------------------------------
	a_irq_combine: assert property (irq == |(s.raw & $past(s.mask)))
		else $error("irq not raw and mask");

	a_mask_block: assert property (s.mask == 8'h00 |=> !irq)
		else $error("masked pin raised irq");

	a_clear_bit: assert property (wr_go && address == gpio_pkg::OFF_CLR && wd[0] && !event_hit[0]
		|=> !s.raw[0]) else $error("clear did not clear");

	a_set_wins: assert property (wr_go && address == gpio_pkg::OFF_CLR && event_hit[0]
		|=> s.raw[0]) else $error("clear beat a new event");

	a_raw_sticky: assert property (s.raw[0] && !(wr_go && address == gpio_pkg::OFF_CLR)
		|=> s.raw[0]) else $error("raw bit lost");

	a_rise_detect: assert property (!s.sense[0] && !s.both[0] && s.pol[0] && rise[0] |=> s.raw[0])
		else $error("rising edge missed");

	a_fall_detect: assert property (!s.sense[0] && !s.both[0] && !s.pol[0] && fall[0] |=> s.raw[0])
		else $error("falling edge missed");

	a_both_detect: assert property (!s.sense[0] && s.both[0] && (rise[0] || fall[0]) |=> s.raw[0])
		else $error("edge missed in both-edges mode");

	a_level_detect: assert property (s.sense[0] && !s.pol[0] && !level_in[0] |=> s.raw[0])
		else $error("low level missed");

	a_high_level: assert property (s.sense[0] && s.pol[0] && level_in[0] |=> s.raw[0])
		else $error("high level missed");

	a_edge_quiet: assert property (!s.sense[0] && !edge_hit[0] && !s.raw[0] |=> !s.raw[0])
		else $error("edge pin raised without edge");

	a_masked_read: assert property (req && read && address == gpio_pkg::OFF_MIS
		|=> readdata[7:0] == $past(s.raw & s.mask)) else $error("masked status wrong");

	for (genvar i = 0; i < 8; i++) begin : g_pin_irq
		a_pin_irq: assert property (s.mask[i] && next_s.raw[i] |=> irq)
			else $error("pin interrupt not combined");
	end

	//------------------------------------------------------------
	// Assertions: data and direction
	//------------------------------------------------------------
	a_data_mask: assert property (wr_go && is_data_window(address) && !wmask[0]
		|=> s.data[0] == $past(din[0])) else $error("masked data bit changed");

	a_data_write: assert property (wr_go && is_data_window(address) && wmask[0] && s.dir[0]
		|=> s.data[0] == $past(wd[0])) else $error("unmasked data bit not written");

	a_read_mask: assert property (req && read && is_data_window(address) && !wmask[1]
		|=> !readdata[1]) else $error("masked bit read nonzero");

	a_input_capture: assert property (!s.dir[0] |=> s.data[0] == $past(level_in[0]))
		else $error("input level not captured");

	a_sync_chain: assert property (s.sync2 == $past(s.sync1))
		else $error("synchroniser skipped a stage");

	//------------------------------------------------------------
	// Assertions: alternate function and lock
	//------------------------------------------------------------
	a_alt_drive: assert property (s.alt[0] |=> pin_oe[0] == $past(alt_oe[0]))
		else $error("alt drive wrong");

	a_sw_drive: assert property (!s.alt[0] |=> pin_oe[0] == $past(s.dir[0]))
		else $error("direction not driving pin");

	a_alt_lock: assert property (wr_go && address == gpio_pkg::OFF_ALT && !s.commit[0]
		|=> s.alt[0] == $past(s.alt[0])) else $error("protected alt written");

	a_commit_lock: assert property (!s.unlocked && wr_go && address == gpio_pkg::OFF_COMMIT
		|=> $stable(s.commit)) else $error("commit changed while locked");

	//------------------------------------------------------------
	// Assertions: pad control and reset
	//------------------------------------------------------------
	a_drive_excl: assert property ((s.dr2 & s.dr4) == 8'h00 && (s.dr2 & s.dr8) == 8'h00
		&& (s.dr4 & s.dr8) == 8'h00) else $error("two drive strengths selected");

	a_din_gate: assert property (alt_in == $past(level_in & s.den))
		else $error("digital enable not gating input");

	a_reset_pins: assert property ($rose(rst_n) |-> s.dir == 8'h00 && s.alt == DEBUG_PINS
		&& s.pdr == 8'h00 && pin_oe == 8'h00) else $error("pins not at reset default");

	a_reset_quiet: assert property ($rose(rst_n) |-> !irq && waitrequest && s.raw == 8'h00)
		else $error("interrupt or bus not idle after reset");

	c_edge_irq: cover property (!s.sense[0] && rise[0] ##1 irq);
	c_clear: cover property (wr_go && address == gpio_pkg::OFF_CLR);
	c_data_write: cover property (wr_go && is_data_window(address) && wmask != 8'hFF);
	c_unlock: cover property (s.unlocked ##1 wr_go && address == gpio_pkg::OFF_COMMIT);
	c_level_irq: cover property (s.sense[3] && s.raw[3] && irq);
endmodule

/* File: tb/pin_model.sv */
// Package-pin and peripheral model facing the port
module pin_model (
	// From the port, plus the outside pin level
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] ext_level,
	// Toward the port
	output logic [7:0] pin_in,
	output logic [7:0] alt_out,
	output logic [7:0] alt_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Driven pins read back their own level, the others follow the outside source
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
	assign alt_out = 8'hA5;
	assign alt_oe = 8'h3C;
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the general-purpose I/O port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, read, write, waitrequest, irq;
	logic [11:0] address;
	logic [31:0] writedata, readdata, q;
	logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext_level;
	logic [7:0] pad_dr2, pad_dr4, pad_dr8, pad_odr, pad_pur, pad_pdr, pad_slr, pad_den;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	gpio_port_pin_control #(.DEBUG_PINS(8'h0F), .ID_VALUE0(8'h3C)) dut (.mclk, .rst_n, .address, .read,
		.write, .writedata, .readdata, .waitrequest, .pin_in, .pin_out, .pin_oe, .alt_out, .alt_oe, .alt_in,
		.pad_dr2, .pad_dr4, .pad_dr8, .pad_odr, .pad_pur, .pad_pdr, .pad_slr, .pad_den, .irq);
	pin_model partner (.pin_oe, .pin_out, .ext_level, .pin_in, .alt_out, .alt_oe);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			give_verdict();
		end
	end
	//----------------------------------------
	// Bus and compare helpers
	//----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		do @(posedge mclk); while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
	endtask
	//----------------------------------------
	// Scenarios
	//----------------------------------------
	task automatic t_reset;
		rd(gpio_pkg::OFF_DIR, 32'h0);
		rd(gpio_pkg::OFF_ALT, 32'h0F);
		rd(gpio_pkg::OFF_PUR, 32'h0F);
		rd(gpio_pkg::OFF_DEN, 32'h0F);
		rd(gpio_pkg::OFF_PDR, 32'h0);
		rd(gpio_pkg::OFF_DR2, 32'hFF);
		chk(pin_oe, 32'h0C);
		wr(gpio_pkg::OFF_ID_BASE, 32'h0);
		rd(gpio_pkg::OFF_ID_BASE, 32'h3C);
		rd(12'h600, 32'h0);
	endtask
	task automatic t_lock;
		rd(gpio_pkg::OFF_LOCK, gpio_pkg::LOCKED_READ);
		wr(gpio_pkg::OFF_ALT, 32'hF0);
		rd(gpio_pkg::OFF_ALT, 32'hFF);
		wr(gpio_pkg::OFF_COMMIT, 32'hFF);
		wr(gpio_pkg::OFF_ALT, 32'h0);
		rd(gpio_pkg::OFF_ALT, 32'h0F);
		wr(gpio_pkg::OFF_LOCK, gpio_pkg::LOCK_KEY);
		rd(gpio_pkg::OFF_LOCK, 32'h0);
		wr(gpio_pkg::OFF_COMMIT, 32'hFF);
		wr(gpio_pkg::OFF_ALT, 32'h0C);
		rd(gpio_pkg::OFF_ALT, 32'h0C);
		idle(4);
		chk(pin_oe, 32'h0C);
		chk(pin_out & 8'h0C, 32'h04);
		chk(alt_in, 32'h04);
		wr(gpio_pkg::OFF_ALT, 32'h0);
		wr(gpio_pkg::OFF_LOCK, 32'h0);
		rd(gpio_pkg::OFF_LOCK, gpio_pkg::LOCKED_READ);
	endtask
	task automatic t_data;
		wr(gpio_pkg::OFF_DIR, 32'hFF);
		wr(12'h098, 32'hEB);
		rd(12'h3FC, 32'h22);
		rd(12'h0C4, 32'h20);
		idle(2);
		chk(pin_out, 32'h22);
		chk(pin_oe, 32'hFF);
		ext_level <= 8'h50;
		wr(gpio_pkg::OFF_DIR, 32'h0F);
		idle(4);
		rd(12'h3FC, 32'h52);
	endtask
	task automatic t_irq;
		ext_level <= 8'h12;
		wr(gpio_pkg::OFF_DIR, 32'h0);
		wr(gpio_pkg::OFF_MASK, 32'h0);
		wr(gpio_pkg::OFF_SENSE, 32'h18);
		wr(gpio_pkg::OFF_BOTH, 32'h04);
		wr(gpio_pkg::OFF_POL, 32'h09);
		idle(4);
		wr(gpio_pkg::OFF_CLR, 32'hFF);
		rd(gpio_pkg::OFF_RAW, 32'h0);
		ext_level <= 8'h0D;
		idle(5);
		wr(gpio_pkg::OFF_CLR, 32'h0);
		rd(gpio_pkg::OFF_RAW, 32'h1F);
		rd(gpio_pkg::OFF_MIS, 32'h0);
		chk(irq, 32'h0);
		wr(gpio_pkg::OFF_MASK, 32'h03);
		idle(2);
		rd(gpio_pkg::OFF_MIS, 32'h03);
		chk(irq, 32'h1);
		wr(gpio_pkg::OFF_CLR, 32'h1F);
		rd(gpio_pkg::OFF_RAW, 32'h18);
		idle(2);
		chk(irq, 32'h0);
	endtask
	task automatic t_pad;
		wr(gpio_pkg::OFF_DR8, 32'h01);
		wr(gpio_pkg::OFF_SLR, 32'h01);
		wr(gpio_pkg::OFF_ODR, 32'h02);
		wr(gpio_pkg::OFF_DEN, 32'hFF);
		idle(2);
		chk(pad_dr2, 32'hFE);
		chk(pad_dr4, 32'h00);
		chk(pad_odr, 32'h02);
		chk(pad_pur, 32'h0F);
		chk(pad_pdr, 32'h00);
		chk(pad_den, 32'hFF);
		chk(alt_in, 32'h0D);
		chk(pad_dr8, 32'h01);
		chk(pad_slr, 32'h01);
	endtask
	task automatic t_rerst;
		do_reset();
		rd(gpio_pkg::OFF_ALT, 32'h0F);
		rd(gpio_pkg::OFF_DR8, 32'h0);
		chk(pin_oe, 32'h0C);
	endtask
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		read = 1'b0;
		write = 1'b0;
		address = 12'h0;
		writedata = 32'h0;
		ext_level = 8'h0;
		do_reset();
		t_reset();
		t_lock();
		t_data();
		t_irq();
		t_pad();
		t_rerst();
		give_verdict();
	end
endmodule
